//--- logic/slr_consts.svh
// Constants for the serial link status, sequence and address registers.
// Assumes inclusion by the package and the register bank only.
`ifndef SLR_CONSTS_SVH
`define SLR_CONSTS_SVH
// ----------------------------------------
// Register selects on the special function port
// ----------------------------------------
`define SLR_SEL_STATUS 2'h0
`define SLR_SEL_SEQ 2'h1
`define SLR_SEL_ADDR 2'h2
// ----------------------------------------
// Status/command bit positions
// ----------------------------------------
`define SLR_ST_PROT 0
`define SLR_ST_MODE 1
`define SLR_ST_POLL 2
`define SLR_ST_OVR 3
`define SLR_ST_IRQ 4
`define SLR_ST_TXREQ 5
`define SLR_ST_RXEN 6
`define SLR_ST_TXBUF 7
// ----------------------------------------
// Sequence-count bit positions
// ----------------------------------------
`define SLR_SQ_RERR 0
`define SLR_SQ_NR_LO 1
`define SLR_SQ_SERR 4
`define SLR_SQ_NS_LO 5
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SLR_RST_STATUS 8'h00
`define SLR_RST_SEQ 8'h00
`define SLR_RST_ADDR 8'h00
`define SLR_RST_RDATA 8'h00
`endif

//--- logic/slr_pkg.sv
// Types shared by the serial link register bank.
// Assumes the constants header is on the include path.
`include "slr_consts.svh"
package slr_pkg;
  // CPU access: byte write, or a single-bit write to a bit-addressable register.
  typedef struct packed {
    logic [1:0] sel;
    logic byte_we;
    logic bit_we;
    logic [2:0] bit_idx;
    logic bit_val;
    logic [7:0] wdata;
  } slr_cpu_req_t;
  // One-cycle events and writes from the serial unit.
  typedef struct packed {
    logic clr_mode;
    logic set_irq;
    logic set_ovr;
    logic set_txreq;
    logic clr_txreq;
    logic clr_rxen;
    logic clr_txbuf;
    logic seq_we;
    logic [7:0] seq_wdata;
    logic chk_frame;
    logic [2:0] rx_ns;
    logic [2:0] rx_nr;
  } slr_unit_req_t;
  typedef enum logic [1:0] {
    SLR_MODE_FLEX,
    SLR_MODE_AUTO,
    SLR_MODE_NONADDR,
    SLR_MODE_ADDR
  } slr_mode_t;
endpackage : slr_pkg

//--- logic/slr_regs.sv
// Status/command, sequence-count and node-address registers shared by CPU and serial unit.
// Assumes CPU and serial unit share i_clk_sys and issue one-cycle requests.
// Behaviour
// - CPU full access; unit writes designated bits
// - Protect bit blocks receive buffer writes
// - Protect in automatic mode answers receive-not-ready
// - Without no-control-field, mode bit selects auto/flexible
// - With no-control-field, mode bit selects addressed
// - Serial unit may clear mode bit
// - Unit sets interrupt flag; CPU clears it
// - Transmit request bit enables transmission
// - Unit may write transmit request in automatic
// - Pin driven only outside loop configuration
// - Request-to-send pin is inverted, active low
// - Unit clears receive enable after frame stored
// - CPU sets transmit-buffer-ready; unit clears it
// - Send counter in bits 7 to 5
// - Receive counter bits 3-1, error flags 4,0
// - Sequence register byte and bit writable
// - Counters untouched by the unit outside automatic mode
// - Node address register, CPU bytewise access
// - No-control-field bit selects non-buffered frames
module slr_regs
  import slr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire slr_cpu_req_t i_cpu,
  input wire slr_unit_req_t i_unit,
  input wire logic i_rx_wr_req,
  input wire logic i_no_ctrl_field,
  input wire logic i_loop_cfg,
  output logic [7:0] o_cpu_rdata,
  output logic [7:0] o_status,
  output logic [7:0] o_seq,
  output logic [7:0] o_node_addr,
  output slr_mode_t o_mode,
  output logic o_auto_mode,
  output logic o_non_buffered,
  output logic o_rx_wr_allow,
  output logic o_reply_rnr,
  output logic o_tx_enable,
  output logic o_irq,
  output logic o_rts_pin_n,
  output logic o_rts_pin_oe
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] seq_r;
  logic [7:0] seq_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  // ----------------------------------------
  // Decoded requests
  // ----------------------------------------
  logic auto_w;
  logic cpu_st_byte;
  logic cpu_st_bit;
  logic cpu_sq_byte;
  logic cpu_sq_bit;
  logic cpu_ad_byte;
  logic unit_sq_we;
  logic unit_chk;
  logic unit_set_txreq;
  logic unit_clr_txreq;
  logic [7:0] st_cpu;
  logic [7:0] sq_cpu;
  logic [7:0] st_clr;
  logic [7:0] st_set;
  logic [7:0] sq_set;
  logic [2:0] ns_cur;
  logic [2:0] nr_cur;
  logic [2:0] ns_inc;
  logic rx_seq_bad;
  logic tx_seq_bad;

  assign auto_w = status_r[`SLR_ST_MODE] & ~i_no_ctrl_field;
  assign cpu_st_byte = i_cpu.byte_we && (i_cpu.sel == `SLR_SEL_STATUS);
  assign cpu_st_bit = i_cpu.bit_we && (i_cpu.sel == `SLR_SEL_STATUS);
  assign cpu_sq_byte = i_cpu.byte_we && (i_cpu.sel == `SLR_SEL_SEQ);
  assign cpu_sq_bit = i_cpu.bit_we && (i_cpu.sel == `SLR_SEL_SEQ);
  // The address register is byte addressable only, so bit writes to it are dropped.
  assign cpu_ad_byte = i_cpu.byte_we && (i_cpu.sel == `SLR_SEL_ADDR);
  // Transmit request and the counters belong to the unit only in automatic mode.
  assign unit_set_txreq = auto_w && i_unit.set_txreq;
  assign unit_clr_txreq = auto_w && i_unit.clr_txreq;
  assign unit_sq_we = auto_w && i_unit.seq_we;
  assign unit_chk = auto_w && i_unit.chk_frame;

  // ----------------------------------------
  // CPU write merge
  // ----------------------------------------
  slr_cpu_merge #(
    .W(8)
  ) i_st_merge (
    .i_cur(status_r),
    .i_byte_we(cpu_st_byte),
    .i_bit_we(cpu_st_bit),
    .i_bit_idx(i_cpu.bit_idx),
    .i_bit_val(i_cpu.bit_val),
    .i_wdata(i_cpu.wdata),
    .o_merged(st_cpu)
  );

  slr_cpu_merge #(
    .W(8)
  ) i_sq_merge (
    .i_cur(seq_r),
    .i_byte_we(cpu_sq_byte),
    .i_bit_we(cpu_sq_bit),
    .i_bit_idx(i_cpu.bit_idx),
    .i_bit_val(i_cpu.bit_val),
    .i_wdata(i_cpu.wdata),
    .o_merged(sq_cpu)
  );

  // ----------------------------------------
  // Sequence checks
  // ----------------------------------------
  assign ns_cur = seq_r[`SLR_SQ_NS_LO +: 3];
  assign nr_cur = seq_r[`SLR_SQ_NR_LO +: 3];
  // The send count wraps modulo eight, as the three-bit field does.
  assign ns_inc = 3'(ns_cur + 3'h1);
  assign rx_seq_bad = i_unit.rx_ns != nr_cur;
  // An acknowledge of the current frame or of the next one (send count plus one) is accepted.
  assign tx_seq_bad = (i_unit.rx_nr != ns_cur) && (i_unit.rx_nr != ns_inc);

  // ----------------------------------------
  // Status/command register
  // ----------------------------------------
  // Unit clears act after the CPU write and unit sets after both, so no event is lost.
  always_comb begin
    st_clr = 8'h00;
    st_set = 8'h00;
    st_clr[`SLR_ST_MODE] = i_unit.clr_mode;
    st_clr[`SLR_ST_RXEN] = i_unit.clr_rxen;
    st_clr[`SLR_ST_TXBUF] = i_unit.clr_txbuf;
    st_clr[`SLR_ST_TXREQ] = unit_clr_txreq;
    st_set[`SLR_ST_TXREQ] = unit_set_txreq;
    st_set[`SLR_ST_OVR] = i_unit.set_ovr;
    st_set[`SLR_ST_IRQ] = i_unit.set_irq;
    status_nxt = (st_cpu & ~st_clr) | st_set;
  end

  slr_reg #(
    .W(8),
    .RST(`SLR_RST_STATUS)
  ) i_status_reg (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_d(status_nxt),
    .o_q(status_r)
  );

  // ----------------------------------------
  // Sequence-count register
  // ----------------------------------------
  always_comb begin
    sq_set = 8'h00;
    sq_set[`SLR_SQ_RERR] = unit_chk && rx_seq_bad;
    sq_set[`SLR_SQ_SERR] = unit_chk && tx_seq_bad;
    seq_nxt = sq_cpu;
    // The unit's own write wins over a CPU write in the same cycle.
    if (unit_sq_we) begin
      seq_nxt = i_unit.seq_wdata;
    end
    seq_nxt = seq_nxt | sq_set;
  end

  slr_reg #(
    .W(8),
    .RST(`SLR_RST_SEQ)
  ) i_seq_reg (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_d(seq_nxt),
    .o_q(seq_r)
  );

  // ----------------------------------------
  // Node-address register
  // ----------------------------------------
  always_comb begin
    addr_nxt = addr_r;
    if (cpu_ad_byte) begin
      addr_nxt = i_cpu.wdata;
    end
  end

  slr_reg #(
    .W(8),
    .RST(`SLR_RST_ADDR)
  ) i_addr_reg (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_d(addr_nxt),
    .o_q(addr_r)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Read data shows the value after this cycle's writes, one cycle after the select.
  always_comb begin
    unique case (i_cpu.sel)
      `SLR_SEL_STATUS: rdata_nxt = status_nxt;
      `SLR_SEL_SEQ: rdata_nxt = seq_nxt;
      `SLR_SEL_ADDR: rdata_nxt = addr_nxt;
      default: rdata_nxt = 8'h00;
    endcase
  end

  slr_reg #(
    .W(8),
    .RST(`SLR_RST_RDATA)
  ) i_rdata_reg (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_d(rdata_nxt),
    .o_q(rdata_r)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_cpu_rdata = rdata_r;
  assign o_status = status_r;
  assign o_seq = seq_r;
  assign o_node_addr = addr_r;
  assign o_auto_mode = auto_w;
  assign o_non_buffered = i_no_ctrl_field;
  always_comb begin
    unique case ({i_no_ctrl_field, status_r[`SLR_ST_MODE]})
      2'b00: o_mode = SLR_MODE_FLEX;
      2'b01: o_mode = SLR_MODE_AUTO;
      2'b10: o_mode = SLR_MODE_NONADDR;
      default: o_mode = SLR_MODE_ADDR;
    endcase
  end
  assign o_rx_wr_allow = i_rx_wr_req & ~status_r[`SLR_ST_PROT];
  assign o_reply_rnr = auto_w & status_r[`SLR_ST_PROT];
  assign o_tx_enable = status_r[`SLR_ST_TXREQ];
  assign o_irq = status_r[`SLR_ST_IRQ];
  // The pin is released in loop configuration rather than driven high.
  assign o_rts_pin_n = ~status_r[`SLR_ST_TXREQ];
  assign o_rts_pin_oe = ~i_loop_cfg;
endmodule : slr_regs

// ----------------------------------------
// CPU write merge for a bit-addressable register
// ----------------------------------------
module slr_cpu_merge
  import slr_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic [W-1:0] i_cur,
  input wire logic i_byte_we,
  input wire logic i_bit_we,
  input wire logic [2:0] i_bit_idx,
  input wire logic i_bit_val,
  input wire logic [W-1:0] i_wdata,
  output logic [W-1:0] o_merged
);
  // A byte write replaces the whole value; a bit write touches one position only.
  always_comb begin
    o_merged = i_cur;
    if (i_byte_we) begin
      o_merged = i_wdata;
    end
    if (i_bit_we) begin
      o_merged[i_bit_idx] = i_bit_val;
    end
  end
endmodule : slr_cpu_merge

// ----------------------------------------
// Register with asynchronous reset
// ----------------------------------------
module slr_reg
  import slr_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_q <= RST;
    end else begin
      o_q <= i_d;
    end
  end
endmodule : slr_reg

//--- bench/slr_regs_assertions.sv
// Checker for the serial link register bank.
// Assumes it is bound into slr_regs.
module slr_regs_chk
  import slr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire slr_cpu_req_t i_cpu,
  input wire slr_unit_req_t i_unit,
  input wire logic i_rx_wr_req,
  input wire logic i_no_ctrl_field,
  input wire logic i_loop_cfg,
  input wire logic [7:0] o_status,
  input wire logic [7:0] o_seq,
  input wire slr_mode_t o_mode,
  input wire logic o_rx_wr_allow,
  input wire logic o_reply_rnr,
  input wire logic o_rts_pin_n,
  input wire logic o_rts_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // CPU writes may change the counters in any mode, so they are excluded.
  wire cpu_seq = i_cpu.sel == 2'h1 && (i_cpu.byte_we || i_cpu.bit_we);
  a_rts_pin_inv: assert property (o_rts_pin_n == !o_status[5])
    else $error("rts pin level");
  a_rts_pin_oe: assert property (o_rts_pin_oe == !i_loop_cfg)
    else $error("rts pin enable");
  a_protect_gate: assert property (o_rx_wr_allow == (i_rx_wr_req && !o_status[0]))
    else $error("rx write gate");
  a_rnr_reply: assert property (o_reply_rnr == (o_status[0] && o_mode == SLR_MODE_AUTO))
    else $error("rnr reply");
  a_mode_decode: assert property (o_mode == slr_mode_t'({i_no_ctrl_field, o_status[1]}))
    else $error("mode decode");
  a_mode_clear: assert property (i_unit.clr_mode |=> !o_status[1])
    else $error("mode clear");
  a_irq_set: assert property (i_unit.set_irq |=> o_status[4])
    else $error("irq set");
  a_rx_stop: assert property (i_unit.clr_rxen |=> !o_status[6])
    else $error("rx enable clear");
  a_tx_done: assert property (i_unit.clr_txbuf |=> !o_status[7])
    else $error("tx buffer clear");
  a_seq_hold: assert property (o_mode != SLR_MODE_AUTO && !cpu_seq |=> $stable(o_seq))
    else $error("seq changed");
  c_frame: cover property (i_unit.chk_frame && o_mode == SLR_MODE_AUTO);
  c_rnr: cover property (o_reply_rnr);
  c_loop: cover property (i_loop_cfg && !o_rts_pin_n);
endmodule : slr_regs_chk
bind slr_regs slr_regs_chk i_chk (.*);

//--- bench/slr_cpu_model.sv
// CPU side model: one-cycle byte or bit writes and registered reads.
// Assumes one bench process calls its tasks, just after a rising edge.
module slr_cpu_model
  import slr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  output slr_cpu_req_t o_cpu
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_cpu = '0;
  // A released data bus shows the inverse, so stale data is never taken.
  task automatic wr(input logic [1:0] s, input logic b, input logic [2:0] i, input logic [7:0] d);
    o_cpu = '{sel: s, byte_we: !b, bit_we: b, bit_idx: i, bit_val: d[0], wdata: d};
    @(posedge i_clk_sys);
    #1;
    o_cpu = '{sel: s, bit_idx: i, bit_val: !d[0], wdata: ~d, default: '0};
    @(posedge i_clk_sys);
    #1;
  endtask : wr
  task automatic rd(input logic [1:0] s, output logic [7:0] q);
    o_cpu.sel = s;
    @(posedge i_clk_sys);
    #1;
    q = i_rdata;
  endtask : rd
endmodule : slr_cpu_model

//--- bench/slr_regs_tb_top.sv
// Bench for the serial link register bank.
// Assumes the CPU model and the bound checker are compiled first.
module slr_regs_tb_top
  import slr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, ncf = 1'b0, loop = 1'b0;
  slr_cpu_req_t cpu;
  slr_unit_req_t u = '0;
  logic [7:0] rd, st, sq, q;
  slr_mode_t md;
  logic rx_ok, rts_n, rts_oe, rxq = 1'b1, am, nb, receive_not_ready_reply, txe, irq;
  logic [7:0] na;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  initial forever #20 clk = !clk;
  slr_cpu_model i_cpu_m (.i_clk_sys(clk), .i_rdata(rd), .o_cpu(cpu));
  slr_regs i_dut (.i_clk_sys(clk), .i_rst(rst), .i_cpu(cpu), .i_unit(u), .i_rx_wr_req(rxq),
    .i_no_ctrl_field(ncf), .i_loop_cfg(loop), .o_cpu_rdata(rd), .o_status(st), .o_seq(sq),
    .o_node_addr(na), .o_mode(md), .o_auto_mode(am), .o_non_buffered(nb),
    .o_rx_wr_allow(rx_ok), .o_reply_rnr(receive_not_ready_reply), .o_tx_enable(txe), .o_irq(irq),
    .o_rts_pin_n(rts_n), .o_rts_pin_oe(rts_oe));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic pulse(input slr_unit_req_t p);
    u = p;
    @(posedge clk);
    #1;
    u = '0;
    @(posedge clk);
    #1;
  endtask : pulse
  task automatic summarize();
    $display("Checked %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("status", 8'h00, st);
    chk("rts_n", 8'h01, rts_n);
    chk("rts_oe", 8'h01, rts_oe);
    i_cpu_m.wr(2'h2, 1'b0, 3'h0, 8'ha5);
    i_cpu_m.rd(2'h2, q);
    chk("addr", 8'ha5, q);
    chk("node_addr", 8'ha5, na);
    pulse('{seq_we: 1'b1, seq_wdata: 8'hff, default: '0});
    chk("seq", 8'h00, sq);
    i_cpu_m.wr(2'h0, 1'b0, 3'h0, 8'h42);
    chk("mode", 8'(SLR_MODE_AUTO), md);
    chk("auto", 8'h01, am);
    ncf = 1'b1;
    #1 chk("mode", 8'(SLR_MODE_ADDR), md);
    chk("auto", 8'h00, am);
    chk("non_buf", 8'h01, nb);
    ncf = 1'b0;
    pulse('{seq_we: 1'b1, seq_wdata: 8'he0, default: '0});
    chk("seq", 8'he0, sq);
    i_cpu_m.wr(2'h1, 1'b1, 3'h1, 8'h01);
    chk("seq", 8'he2, sq);
    pulse('{chk_frame: 1'b1, rx_ns: 3'h3, rx_nr: 3'h5, default: '0});
    chk("seq", 8'hf3, sq);
    i_cpu_m.wr(2'h0, 1'b1, 3'h0, 8'h01);
    chk("rx_ok", 8'h00, rx_ok);
    chk("rnr", 8'h01, receive_not_ready_reply);
    i_cpu_m.wr(2'h0, 1'b1, 3'h0, 8'h00);
    chk("rx_ok", 8'h01, rx_ok);
    chk("rnr", 8'h00, receive_not_ready_reply);
    rxq = 1'b0;
    #1 chk("rx_ok", 8'h00, rx_ok);
    rxq = 1'b1;
    pulse('{set_txreq: 1'b1, set_irq: 1'b1, set_ovr: 1'b1, default: '0});
    chk("status", 8'h7a, st);
    chk("tx_en", 8'h01, txe);
    chk("irq", 8'h01, irq);
    loop = 1'b1;
    #1 chk("rts", 8'h00, {rts_n, rts_oe});
    i_cpu_m.wr(2'h0, 1'b1, 3'h4, 8'h00);
    chk("irq", 8'h00, irq);
    i_cpu_m.wr(2'h0, 1'b1, 3'h7, 8'h01);
    chk("status", 8'hea, st);
    pulse('{clr_txbuf: 1'b1, clr_rxen: 1'b1, clr_mode: 1'b1, default: '0});
    chk("status", 8'h28, st);
    pulse('{clr_txreq: 1'b1, default: '0});
    chk("status", 8'h28, st);
    summarize();
  end
endmodule : slr_regs_tb_top
